// *** verilog/pwm_fault_defines.vh ***
// Constants for the PWM fault-protection and reset-state block
`ifndef PWM_FAULT_DEFINES_VH
`define PWM_FAULT_DEFINES_VH

// =====================================
// Register byte addresses
`define ADDR_FAULT_CFG 8'h00
`define ADDR_OUT_CTRL 8'h04
`define ADDR_IRQ_STAT 8'h08
`define ADDR_IRQ_MASK 8'h0C
`define ADDR_PERIOD 8'h10

// =====================================
// Fault configuration fields
`define FC_A_EN 0
`define FC_A_MODE 1
`define FC_A_STAT 2
`define FC_SCOPE 3
`define FC_B_EN 4
`define FC_B_MODE 5
`define FC_B_STAT 6
`define FC_BRK_EN 7
`define FC_RESET 8'h00

// =====================================
// Output enable field reset codes
`define OE_RESET_OFF 3'h0
`define OE_RESET_8 3'h5
`define OE_RESET_6 3'h4

// =====================================
// Interrupt status bits
`define IRQ_FAULT_A 0
`define IRQ_FAULT_B 1
`define IRQ_PERIOD 2

// =====================================
// AXI responses and default period
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define PERIOD_RESET 16'h00FF

`endif

// *** verilog/pwm_fault_reset.v ***
// PWM output stage with fault override, reset-state loading and AXI4-Lite registers
`timescale 1ns/100ps
`include "pwm_fault_defines.vh"

// Behaviour
// R1: With the reset-state strap unprogrammed, reset clears the output enable field so all pins float.
// R2: With the strap programmed low, reset loads 101 for eight outputs or 100 for six.
// R3: Outputs enabled at reset drive PWM using the high and low side polarity straps.
// R4: Two active-low fault inputs A and B exist, and wired sources may pull either low.
// R5: An enabled fault forces outputs to their polarity-defined inactive level in hardware.
// R6: A fault acts only while its enable bit (bit 0 for A, bit 4 for B) is set.
// R7: Catastrophic mode holds outputs inactive until the input is high and software clears status, resuming next period.
// R8: Cycle-by-cycle mode holds outputs inactive while the input is low, then resumes next period and clears status itself.
// R9: Status bit 2 for A and 6 for B reads 1 while the fault is asserted or latched.
// R10: Scope bit 3 set faults all eight outputs, cleared only outputs five to zero.
// R11: On the six-output variant the scope bit has no effect.
// R12: On the six-output variant software keeps the fault B bits cleared.
// R13: Fault inputs are synchronised and the override acts within a few clocks.
module pwm_fault_reset #(
	parameter NUM_OUT = 8,
	parameter PERIOD_W = 16
) (
	input wire core_clk,
	input wire srst,
	input wire outputsAtResetCfg_n,
	input wire highSidePolarity,
	input wire lowSidePolarity,
	input wire faultAIn_n,
	input wire faultBIn_n,
	input wire [NUM_OUT-1:0] pwmRaw,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [NUM_OUT-1:0] pwmOut,
	output reg [NUM_OUT-1:0] pwmOutEn,
	output reg periodStart,
	output reg irq
);
	// Fault B and pins 7 and 6 exist only on the eight-output variant
	localparam HAS_B = (NUM_OUT > 6) ? 1'b1 : 1'b0;

	// =====================================
	// Registers
	reg [7:0] faultConfig_reg;
	reg [2:0] outputEnableField_reg;
	reg [PERIOD_W-1:0] period_reg;
	reg [PERIOD_W-1:0] periodCnt_reg;
	reg [2:0] irqStat_reg;
	reg [2:0] irqMask_reg;
	reg faultASync1_reg;
	reg faultASync2_reg;
	reg faultBSync1_reg;
	reg faultBSync2_reg;
	reg faultALatch_reg;
	reg faultBLatch_reg;
	reg blockA_reg;
	reg blockB_reg;
	reg [7:0] awAddr_reg;
	reg awHeld_reg;
	reg [31:0] wData_reg;
	reg [3:0] wStrb_reg;
	reg wHeld_reg;

	// Live fault levels after synchronisation
	wire faultAAct = ~faultASync2_reg;
	wire faultBAct = ~faultBSync2_reg & HAS_B;
	wire enA = faultConfig_reg[`FC_A_EN];
	wire enB = faultConfig_reg[`FC_B_EN] & HAS_B;
	wire periodEnd = (periodCnt_reg >= period_reg);
	wire doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
	wire wrCfg = doWrite & (awAddr_reg == `ADDR_FAULT_CFG) & wStrb_reg[0];
	wire doRead = s_axi_arvalid & s_axi_arready;

	// Status bits: a live fault sets, a write of 0 clears only once the pin is high
	// Cycle mode clears at the period wrap, catastrophic mode only on a write of 0
	wire aStatNext = faultConfig_reg[`FC_A_STAT];
	wire bStatNext = faultConfig_reg[`FC_B_STAT];
	reg statA;
	reg statB;
	always @* begin
		statA = aStatNext;
		statB = bStatNext;
		if (enA && faultAAct)
			statA = 1'b1; // [R9]
		else if (faultConfig_reg[`FC_A_MODE] && periodEnd)
			statA = 1'b0; // [R8]
		else if (!faultConfig_reg[`FC_A_MODE] && wrCfg && !wData_reg[`FC_A_STAT])
			statA = 1'b0; // [R7]
		if (enB && faultBAct)
			statB = 1'b1; // [R9]
		else if (faultConfig_reg[`FC_B_MODE] && periodEnd)
			statB = 1'b0; // [R8]
		else if (!faultConfig_reg[`FC_B_MODE] && wrCfg && !wData_reg[`FC_B_STAT])
			statB = 1'b0; // [R7]
	end

	// =====================================
	// Fault synchronisers and blocking state
	// Only the second flop is read, so a late-settling first stage never reaches the logic
	always @(posedge core_clk) begin
		if (srst) begin
			faultASync1_reg <= 1'b1;
			faultASync2_reg <= 1'b1;
			faultBSync1_reg <= 1'b1;
			faultBSync2_reg <= 1'b1;
		end else begin
			faultASync1_reg <= faultAIn_n; // [R4] [R13]
			faultASync2_reg <= faultASync1_reg;
			faultBSync1_reg <= faultBIn_n;
			faultBSync2_reg <= faultBSync1_reg;
		end
	end

	// Block stays set until a period boundary sees the status cleared, so resume is period aligned
	// Cycle mode waits on the live pin only, otherwise its own auto-clear would cost one more period
	always @(posedge core_clk) begin
		if (srst) begin
			blockA_reg <= 1'b0;
			blockB_reg <= 1'b0;
		end else begin
			if (enA && (faultAAct || (faultConfig_reg[`FC_A_STAT] && !faultConfig_reg[`FC_A_MODE])))
				blockA_reg <= 1'b1; // [R5] [R6]
			else if (periodEnd)
				blockA_reg <= 1'b0; // [R7] [R8]
			if (enB && (faultBAct || (faultConfig_reg[`FC_B_STAT] && !faultConfig_reg[`FC_B_MODE])))
				blockB_reg <= 1'b1; // [R5] [R6]
			else if (periodEnd)
				blockB_reg <= 1'b0; // [R7] [R8]
		end
	end

	// Immediate combined override: live fault bypasses the blocking flop for speed
	wire forceOff = blockA_reg | blockB_reg | (enA & faultAAct) | (enB & faultBAct); // [R13]
	wire scopeAll = faultConfig_reg[`FC_SCOPE] | ~HAS_B; // [R10] [R11]

	// =====================================
	// Period counter
	// Compare uses >= so shrinking the period below the count wraps at once
	always @(posedge core_clk) begin
		if (srst) begin
			periodCnt_reg <= {PERIOD_W{1'b0}};
			periodStart <= 1'b0;
		end else begin
			periodStart <= periodEnd;
			if (periodEnd)
				periodCnt_reg <= {PERIOD_W{1'b0}};
			else
				periodCnt_reg <= periodCnt_reg + 1'b1;
		end
	end

	// =====================================
	// Output stage, one slice per pin
	// The forced level wins over the raw demand; the enable only gates the pin driver
	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g = g + 1) begin : gOut
			wire activeLvl = (g % 2 == 0) ? highSidePolarity : lowSidePolarity;
			wire pinEn = (outputEnableField_reg != `OE_RESET_OFF) &&
				((g < 6) || (outputEnableField_reg == `OE_RESET_8));
			wire killed = forceOff & ((g < 6) | scopeAll);
			always @(posedge core_clk) begin
				if (srst) begin
					pwmOut[g] <= 1'b0;
					pwmOutEn[g] <= 1'b0;
				end else begin
					pwmOutEn[g] <= pinEn; // [R1] [R3]
					pwmOut[g] <= killed ? ~activeLvl : (pwmRaw[g] ? activeLvl : ~activeLvl); // [R3] [R5]
				end
			end
		end
	endgenerate

	// =====================================
	// Register file and interrupts
	// Status bits are hardware-owned, so a written 1 leaves them unchanged
	always @(posedge core_clk) begin
		if (srst) begin
			faultConfig_reg <= `FC_RESET;
			outputEnableField_reg <= outputsAtResetCfg_n ? `OE_RESET_OFF :
				(HAS_B ? `OE_RESET_8 : `OE_RESET_6); // [R1] [R2]
			period_reg <= `PERIOD_RESET;
			irqStat_reg <= 3'h0;
			irqMask_reg <= 3'h0;
			faultALatch_reg <= 1'b0;
			faultBLatch_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wrCfg) begin
				faultConfig_reg[`FC_A_EN] <= wData_reg[`FC_A_EN];
				faultConfig_reg[`FC_A_MODE] <= wData_reg[`FC_A_MODE];
				faultConfig_reg[`FC_SCOPE] <= wData_reg[`FC_SCOPE];
				faultConfig_reg[`FC_B_EN] <= wData_reg[`FC_B_EN] & HAS_B; // [R12]
				faultConfig_reg[`FC_B_MODE] <= wData_reg[`FC_B_MODE] & HAS_B;
				faultConfig_reg[`FC_BRK_EN] <= wData_reg[`FC_BRK_EN];
			end
			faultConfig_reg[`FC_A_STAT] <= statA;
			faultConfig_reg[`FC_B_STAT] <= statB;
			if (doWrite && awAddr_reg == `ADDR_OUT_CTRL && wStrb_reg[0])
				outputEnableField_reg <= wData_reg[2:0];
			if (doWrite && awAddr_reg == `ADDR_IRQ_MASK && wStrb_reg[0])
				irqMask_reg <= wData_reg[2:0];
			if (doWrite && awAddr_reg == `ADDR_PERIOD) begin
				if (wStrb_reg[0])
					period_reg[7:0] <= wData_reg[7:0];
				if (wStrb_reg[1])
					period_reg[PERIOD_W-1:8] <= wData_reg[PERIOD_W-1:8];
			end
			faultALatch_reg <= enA & faultAAct;
			faultBLatch_reg <= enB & faultBAct;
			// Event set wins over the read clear in the same cycle
			irqStat_reg <= ((doRead && s_axi_araddr == `ADDR_IRQ_STAT) ? 3'h0 : irqStat_reg) |
				{periodEnd, enB & faultBAct & ~faultBLatch_reg, enA & faultAAct & ~faultALatch_reg};
			irq <= |(irqStat_reg & irqMask_reg);
		end
	end

	// =====================================
	// AXI4-Lite write channel: address and data latched in either order
	// Each ready is a one-cycle pulse, so a held valid is taken only once
	always @(posedge core_clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			s_axi_awready <= ~awHeld_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHeld_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awAddr_reg == `ADDR_FAULT_CFG || awAddr_reg == `ADDR_OUT_CTRL ||
					awAddr_reg == `ADDR_IRQ_STAT || awAddr_reg == `ADDR_IRQ_MASK ||
					awAddr_reg == `ADDR_PERIOD) ? `RESP_OKAY : `RESP_SLVERR;
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =====================================
	// AXI4-Lite read channel
	// The address is decoded in the handshake cycle; unmapped reads answer with an error
	always @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case (s_axi_araddr)
					`ADDR_FAULT_CFG: s_axi_rdata <= {24'h00_0000, faultConfig_reg};
					`ADDR_OUT_CTRL: s_axi_rdata <= {29'h0000_0000, outputEnableField_reg};
					`ADDR_IRQ_STAT: s_axi_rdata <= {29'h0000_0000, irqStat_reg};
					`ADDR_IRQ_MASK: s_axi_rdata <= {29'h0000_0000, irqMask_reg};
					`ADDR_PERIOD: s_axi_rdata <= {{(32-PERIOD_W){1'b0}}, period_reg};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// *** verif/fault_source.sv ***
// Wired fault sources feeding the two fault lines
`timescale 1ns/100ps
module fault_source (
	input wire [1:0] tripA,
	input wire tripB,
	output wire faultAIn_n,
	output wire faultBIn_n
);
	// Any source pulling low asserts the shared line
	assign faultAIn_n = ~|tripA;
	assign faultBIn_n = ~tripB;
endmodule

// *** verif/pwm_fault_checker.sv ***
// Port-level checks for the PWM fault block
`timescale 1ns/100ps
module pwm_fault_checker #(
	parameter NUM_OUT = 8
) (
	input wire core_clk,
	input wire srst,
	input wire outputsAtResetCfg_n,
	input wire highSidePolarity,
	input wire lowSidePolarity,
	input wire [NUM_OUT-1:0] pwmRaw,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [NUM_OUT-1:0] pwmOut,
	input wire [NUM_OUT-1:0] pwmOutEn,
	input wire periodStart
);
	// ========
	// Checks
	wire [NUM_OUT-1:0] idleLvl = {(NUM_OUT/2){~lowSidePolarity, ~highSidePolarity}};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	oe_reset_a: assert property ($fell(srst) |=> pwmOutEn == (outputsAtResetCfg_n ? '0 : '1))
		else $error("enables wrong after reset");
	// A fault can only push outputs inactive, so this holds in every mode
	idle_level_a: assert property (pwmRaw == '0 |=> pwmOut == $past(idleLvl))
		else $error("idle level wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_lat_a: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read answer late");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready not a pulse");
	w_pulse_a: assert property (s_axi_wready |=> !s_axi_wready)
		else $error("wready not a pulse");
	period_pulse_a: assert property (periodStart |=> !periodStart)
		else $error("period pulse too long");
endmodule
bind pwm_fault_reset pwm_fault_checker #(.NUM_OUT(NUM_OUT)) pwm_fault_checker_inst (.core_clk(core_clk),
	.srst(srst), .outputsAtResetCfg_n(outputsAtResetCfg_n), .highSidePolarity(highSidePolarity),
	.lowSidePolarity(lowSidePolarity), .pwmRaw(pwmRaw), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn),
	.periodStart(periodStart));

// *** verif/tb_top.sv ***
// Self-checking bench for the PWM fault block
`timescale 1ns/100ps
`include "pwm_fault_defines.vh"
module tb_top;
	reg core_clk = 0, srst = 1, cfgN = 1, hiPol = 1, loPol = 0;
	reg awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, smpNow = 0, tripB = 0;
	reg [1:0] tripA = 0;
	reg [7:0] raw = 0, awaddr = 0, araddr = 0;
	reg [31:0] wdata = 0;
	wire fa, fb, awr, wrdy, bv, arr, rv, pStart, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] pOut, pEn;
	integer badCount = 0, nCompared = 0, seed = 96705, k;
	reg [33:0] expQ[$];
	always #5 core_clk = ~core_clk;
	fault_source fault_source_inst (.tripA(tripA), .tripB(tripB), .faultAIn_n(fa), .faultBIn_n(fb));
	pwm_fault_reset pwm_fault_reset_inst (.core_clk(core_clk), .srst(srst), .outputsAtResetCfg_n(cfgN),
		.highSidePolarity(hiPol), .lowSidePolarity(loPol), .faultAIn_n(fa), .faultBIn_n(fb), .pwmRaw(raw),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .pwmOut(pOut),
		.pwmOutEn(pEn), .periodStart(pStart), .irq(irq));
	function [7:0] idl();
		idl = {4{~loPol, ~hiPol}};
	endfunction
	task chk(input [33:0] seen, input [33:0] want);
		begin
			nCompared = nCompared + 1;
			if (seen !== want) begin
				badCount = badCount + 1;
				$display("[ERR] %0t seen %h want %h", $time, seen, want);
			end
		end
	endtask
	task wrapUp();
		begin
			$display("mismatches %0d compares %0d", badCount, nCompared);
			if (badCount == 0 && nCompared > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task wr(input [7:0] a, input [31:0] d, input [1:0] r);
		begin
			expQ.push_back({r, 32'h0000_0000});
			@(posedge core_clk);
			awaddr <= a;
			wdata <= d;
			awv <= 1;
			wv <= 1;
			bry <= 1;
			do begin
				@(posedge core_clk);
				if (awr) awv <= 0;
				if (wrdy) wv <= 0;
			end while (!bv);
			bry <= 0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] d, input [1:0] r);
		begin
			expQ.push_back({r, d});
			@(posedge core_clk);
			araddr <= a;
			arv <= 1;
			rry <= 1;
			do begin
				@(posedge core_clk);
				if (arr) arv <= 0;
			end while (!rv);
			rry <= 0;
		end
	endtask
	task smp(input [16:0] e);
		begin
			expQ.push_back({17'h0_0000, e});
			@(posedge core_clk);
			smpNow <= 1;
			@(posedge core_clk);
			smpNow <= 0;
		end
	endtask
	task rst(input s);
		begin
			@(posedge core_clk);
			srst <= 1;
			cfgN <= s;
			tripA <= 0;
			tripB <= 0;
			repeat (2) @(posedge core_clk);
			srst <= 0;
			wr(`ADDR_PERIOD, 32'h0000_0007, `RESP_OKAY);
		end
	endtask
	// ========
	// Monitor: the oldest note is matched against each result as it shows
	always @(posedge core_clk) begin
		if ((bv && bry) || (rv && rry) || smpNow)
			chk(bv ? {bresp, 32'h0000_0000} : rv ? {rresp, rdata} : {17'h0_0000, irq, pEn, pOut}, expQ.pop_front());
	end
	initial begin
		#100000;
		badCount = badCount + 1;
		wrapUp();
	end
	initial begin
		rst(1);
		smp({1'b0, 8'h00, idl()});
		rd(`ADDR_OUT_CTRL, `OE_RESET_OFF, `RESP_OKAY);
		rd(`ADDR_FAULT_CFG, `FC_RESET, `RESP_OKAY);
		rst(0);
		rd(`ADDR_OUT_CTRL, `OE_RESET_8, `RESP_OKAY);
		@(posedge core_clk);
		tripA <= 2'b01;
		tripB <= 1;
		for (k = 0; k < 4; k = k + 1) begin
			@(posedge core_clk);
			raw <= 8'($random(seed));
			hiPol <= k[0];
			loPol <= k[1];
			repeat (4) @(posedge core_clk);
			smp({1'b0, 8'hFF, raw ^ idl()});
		end
		rst(0);
		wr(`ADDR_FAULT_CFG, 32'h0000_0009, `RESP_OKAY);
		@(posedge core_clk);
		tripA <= 2'b10;
		repeat (4) @(posedge core_clk);
		smp({1'b0, 8'hFF, idl()});
		rd(`ADDR_FAULT_CFG, 32'h0000_000D, `RESP_OKAY);
		@(posedge core_clk);
		tripA <= 0;
		repeat (20) @(posedge core_clk);
		smp({1'b0, 8'hFF, idl()});
		wr(`ADDR_IRQ_MASK, 32'h0000_0001, `RESP_OKAY);
		smp({1'b1, 8'hFF, idl()});
		rd(`ADDR_IRQ_STAT, 32'h0000_0005, `RESP_OKAY);
		wr(`ADDR_FAULT_CFG, 32'h0000_0009, `RESP_OKAY);
		repeat (20) @(posedge core_clk);
		smp({1'b0, 8'hFF, raw ^ idl()});
		rd(`ADDR_FAULT_CFG, 32'h0000_0009, `RESP_OKAY);
		rst(0);
		@(posedge core_clk);
		raw <= 8'hFF;
		wr(`ADDR_FAULT_CFG, 32'h0000_0030, `RESP_OKAY);
		@(posedge core_clk);
		tripB <= 1;
		repeat (4) @(posedge core_clk);
		smp({1'b0, 8'hFF, idl() ^ 8'hC0});
		rd(`ADDR_FAULT_CFG, 32'h0000_0070, `RESP_OKAY);
		@(posedge core_clk);
		tripB <= 0;
		repeat (20) @(posedge core_clk);
		rd(`ADDR_FAULT_CFG, 32'h0000_0030, `RESP_OKAY);
		smp({1'b0, 8'hFF, ~idl()});
		wr(`ADDR_OUT_CTRL, 32'h0000_0004, `RESP_OKAY);
		smp({1'b0, 8'h3F, ~idl()});
		rd(8'h20, 32'h0000_0000, `RESP_SLVERR);
		wr(8'h20, 32'h0000_0005, `RESP_SLVERR);
		wrapUp();
	end
endmodule
